// File: verilog/fbp_pkg.sv
`default_nettype none
package fbp_pkg;
	// Array geometry
	localparam int          FBP_WORD_W      = 32;
	localparam int          FBP_ARRAY_BYTES = 65536;
	localparam int          FBP_BLOCK_BYTES = 1024;
	localparam int          FBP_UNIT_BYTES  = 2048;
	localparam int          FBP_WORDS       = FBP_ARRAY_BYTES / 4;
	localparam int          FBP_ADDR_W      = 14;
	localparam int          FBP_BLK_WORDS   = FBP_BLOCK_BYTES / 4;
	localparam int          FBP_BLK_W       = 8;
	localparam int          FBP_BLOCKS      = FBP_ARRAY_BYTES / FBP_BLOCK_BYTES;
	localparam int          FBP_BLK_IDX_W   = 6;
	localparam int          FBP_UNITS       = FBP_ARRAY_BYTES / FBP_UNIT_BYTES;
	localparam int          FBP_UNIT_IDX_W  = 5;
	// Address field positions within a word address
	localparam int          FBP_BLK_LSB     = 8;
	localparam int          FBP_UNIT_LSB    = 9;
	// Values
	localparam logic [31:0] FBP_ERASED_WORD = 32'hFFFFFFFF;
	localparam logic [31:0] FBP_DENIED_WORD = 32'h00000000;
	localparam logic [7:0]  FBP_LAST_OFF    = 8'hFF;

	typedef enum logic [2:0] {
		FBP_ST_IDLE  = 3'b001,
		FBP_ST_ERASE = 3'b010,
		FBP_ST_DONE  = 3'b100
	} fbp_state_t;
endpackage : fbp_pkg
`default_nettype wire

// File: verilog/fbp_prot_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fbp_prot_if;
	import fbp_pkg::*;
	logic [FBP_ADDR_W-1:0] addr;
	logic [FBP_UNITS-1:0]  ro_mask;
	logic [FBP_UNITS-1:0]  xo_mask;
	logic                  write_locked;
	logic                  exec_only;
	modport checker_side (input addr, ro_mask, xo_mask, output write_locked, exec_only);
	modport user_side    (output addr, ro_mask, xo_mask, input write_locked, exec_only);
endinterface : fbp_prot_if
`default_nettype wire

// File: verilog/fbp_unit_check.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_unit_check
	import fbp_pkg::*;
(
	fbp_prot_if.checker_side prot
);
	wire [FBP_UNIT_IDX_W-1:0] unit_idx;
	wire [FBP_UNITS-1:0]      lock_bits;

	// One protection unit spans two erase blocks
	assign unit_idx = prot.addr[FBP_ADDR_W-1:FBP_UNIT_LSB]; // RULE3

	genvar g;
	generate
		for (g = 0; g < FBP_UNITS; g++) begin : g_unit
			assign lock_bits[g] = prot.ro_mask[g] | prot.xo_mask[g]; // RULE5 RULE6
		end
	endgenerate

	assign prot.write_locked = lock_bits[unit_idx]; // RULE4
	assign prot.exec_only    = prot.xo_mask[unit_idx]; // RULE4
endmodule : fbp_unit_check
`default_nettype wire

// File: verilog/fbp_flash_guard.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RULE1: A 64 KB array made of 1 KB blocks, each erasable on its own.
// RULE2: Erase sets every bit of the chosen block to one, other blocks untouched.
// RULE3: Protection works per 2 KB unit, two adjacent blocks, each unit independent.
// RULE4: Each unit may be marked read-only or execute-only.
// RULE5: Read-only units refuse program and erase; reads are still served.
// RULE6: Execute-only units also refuse program and erase.
// RULE7: Execute-only units answer instruction fetches only, not data or debugger reads.
// RULE8: Permitted reads return data one clock after the request, no wait states.
// RULE9: Unmarked units allow all; refused accesses change nothing and raise a sticky flag. Unmarked units drop programs and erases while busy, flag unset.
// RULE10: Denied reads of execute-only units return a fixed value.
module fbp_flash_guard
	import fbp_pkg::*;
(
	input  wire logic                  clock_in,
	input  wire logic                  srst_in,
	input  wire logic [FBP_UNITS-1:0]  ro_mask_in,
	input  wire logic [FBP_UNITS-1:0]  xo_mask_in,
	input  wire logic                  fetch_req_in,
	input  wire logic [FBP_ADDR_W-1:0] fetch_addr_in,
	input  wire logic                  data_req_in,
	input  wire logic                  data_dbg_in,
	input  wire logic                  data_we_in,
	input  wire logic [FBP_ADDR_W-1:0] data_addr_in,
	input  wire logic [FBP_WORD_W-1:0] data_wdata_in,
	input  wire logic                  erase_req_in,
	input  wire logic [FBP_BLK_IDX_W-1:0] erase_blk_in,
	input  wire logic                  viol_clr_in,
	output logic                       fetch_valid_out,
	output logic [FBP_WORD_W-1:0]      fetch_rdata_out,
	output logic                       data_valid_out,
	output logic [FBP_WORD_W-1:0]      data_rdata_out,
	output logic                       data_denied_out,
	output logic                       erase_busy_out,
	output logic                       erase_done_out,
	output logic                       viol_flag_out
);
	logic [FBP_WORD_W-1:0]     mem [FBP_WORDS]; // RULE1

	fbp_prot_if prot_data ();
	fbp_prot_if prot_erase ();

	fbp_unit_check u_chk_data (
		.prot (prot_data)
	);
	fbp_unit_check u_chk_erase (
		.prot (prot_erase)
	);

	fbp_state_t                state_reg;
	fbp_state_t                state_next;
	logic [FBP_BLK_IDX_W-1:0]  eblk_reg;
	logic [FBP_BLK_W-1:0]      eoff_reg;
	logic                      fetch_valid_reg;
	logic [FBP_WORD_W-1:0]     fetch_rdata_reg;
	logic                      data_valid_reg;
	logic [FBP_WORD_W-1:0]     data_rdata_reg;
	logic                      data_denied_reg;
	logic                      viol_reg;

	wire [FBP_ADDR_W-1:0]      erase_base;
	wire [FBP_ADDR_W-1:0]      erase_waddr;
	wire                       idle;
	wire                       data_read;
	wire                       read_deny;
	wire                       write_ok;
	wire                       write_bad;
	wire                       erase_ok;
	wire                       erase_bad;
	wire                       erasing;
	wire                       viol_event;

	assign prot_data.addr     = data_addr_in;
	assign prot_data.ro_mask  = ro_mask_in;
	assign prot_data.xo_mask  = xo_mask_in;
	assign erase_base         = {erase_blk_in, {FBP_BLK_W{1'b0}}};
	assign prot_erase.addr    = erase_base;
	assign prot_erase.ro_mask = ro_mask_in;
	assign prot_erase.xo_mask = xo_mask_in;

	assign idle        = (state_reg == FBP_ST_IDLE);
	assign erasing     = (state_reg == FBP_ST_ERASE);
	assign erase_waddr = {eblk_reg, eoff_reg}; // RULE2
	assign data_read   = data_req_in & ~data_we_in;
	assign read_deny   = data_read & prot_data.exec_only; // RULE7
	// Writes are taken only when idle, never held; a program to an unlocked unit while busy is dropped silently
	assign write_ok    = data_req_in & data_we_in & idle & ~prot_data.write_locked; // RULE9
	assign write_bad   = data_req_in & data_we_in & prot_data.write_locked; // RULE5 RULE6
	assign erase_ok    = erase_req_in & idle & ~prot_erase.write_locked; // RULE9
	assign erase_bad   = erase_req_in & prot_erase.write_locked; // RULE5 RULE6
	assign viol_event  = write_bad | erase_bad | read_deny; // RULE9

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			FBP_ST_IDLE: begin
				if (erase_ok) begin
					state_next = FBP_ST_ERASE;
				end
			end
			FBP_ST_ERASE: begin
				if (eoff_reg == FBP_LAST_OFF) begin
					state_next = FBP_ST_DONE;
				end
			end
			FBP_ST_DONE: begin
				state_next = FBP_ST_IDLE;
			end
			default: begin
				state_next = FBP_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			state_reg <= FBP_ST_IDLE;
			eblk_reg  <= '0;
			eoff_reg  <= '0;
		end else begin
			state_reg <= state_next;
			if (erase_ok) begin
				eblk_reg <= erase_blk_in;
			end
			eoff_reg <= erasing ? eoff_reg + 8'h01 : 8'h00;
		end
	end

	// Array storage; only one block changes per erase; the lock is checked only when a write or erase is taken, so a running erase is not stopped by it
	always_ff @(posedge clock_in) begin
		if (erasing) begin
			mem[erase_waddr] <= FBP_ERASED_WORD; // RULE2
		end else if (write_ok) begin
			mem[data_addr_in] <= data_wdata_in;
		end
	end

	// Reads: one-cycle answer
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			fetch_valid_reg <= 1'b0;
			fetch_rdata_reg <= '0;
			data_valid_reg  <= 1'b0;
			data_rdata_reg  <= '0;
			data_denied_reg <= 1'b0;
		end else begin
			fetch_valid_reg <= fetch_req_in; // RULE8
			if (fetch_req_in) begin
				fetch_rdata_reg <= mem[fetch_addr_in]; // RULE7
			end
			data_valid_reg  <= data_read; // RULE8
			data_denied_reg <= read_deny;
			if (data_read) begin
				data_rdata_reg <= read_deny ? FBP_DENIED_WORD : mem[data_addr_in]; // RULE10
			end
		end
	end

	// Sticky violation flag, set wins over clear
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			viol_reg <= 1'b0;
		end else if (viol_event) begin
			viol_reg <= 1'b1; // RULE9
		end else if (viol_clr_in) begin
			viol_reg <= 1'b0;
		end
	end

	assign fetch_valid_out = fetch_valid_reg;
	assign fetch_rdata_out = fetch_rdata_reg;
	assign data_valid_out  = data_valid_reg;
	assign data_rdata_out  = data_rdata_reg;
	assign data_denied_out = data_denied_reg;
	assign erase_busy_out  = ~idle;
	assign erase_done_out  = (state_reg == FBP_ST_DONE);
	assign viol_flag_out   = viol_reg;

	property p_read_latency;
		@(posedge clock_in) disable iff (srst_in)
		data_read |=> data_valid_out;
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("Data read not answered next cycle"); // RULE8

	property p_fetch_latency;
		@(posedge clock_in) disable iff (srst_in)
		fetch_req_in |=> fetch_valid_out;
	endproperty
	a_fetch_latency: assert property (p_fetch_latency) else $error("Fetch not answered next cycle"); // RULE8

	property p_xo_deny;
		@(posedge clock_in) disable iff (srst_in)
		(data_read && xo_mask_in[data_addr_in[FBP_ADDR_W-1:FBP_UNIT_LSB]])
			|=> (data_denied_out && data_rdata_out == FBP_DENIED_WORD);
	endproperty
	a_xo_deny: assert property (p_xo_deny) else $error("Execute-only data read leaked"); // RULE7

	property p_denied_const;
		@(posedge clock_in) disable iff (srst_in)
		data_denied_out |-> data_rdata_out == FBP_DENIED_WORD;
	endproperty
	a_denied_const: assert property (p_denied_const) else $error("Denied read value not fixed"); // RULE10

	property p_locked_erase;
		@(posedge clock_in) disable iff (srst_in)
		(erase_req_in && idle && (ro_mask_in[erase_blk_in[FBP_BLK_IDX_W-1:1]]
			|| xo_mask_in[erase_blk_in[FBP_BLK_IDX_W-1:1]])) |=> (idle && viol_flag_out);
	endproperty
	a_locked_erase: assert property (p_locked_erase) else $error("Locked unit erase started"); // RULE5

	property p_locked_write;
		@(posedge clock_in) disable iff (srst_in)
		(data_req_in && data_we_in && xo_mask_in[data_addr_in[FBP_ADDR_W-1:FBP_UNIT_LSB]])
			|-> !write_ok ##1 viol_flag_out;
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("Execute-only unit programmed"); // RULE6

	property p_erase_len;
		@(posedge clock_in) disable iff (srst_in)
		(erase_ok) |=> erase_busy_out ##256 erase_done_out ##1 !erase_busy_out;
	endproperty
	a_erase_len: assert property (p_erase_len) else $error("Erase length wrong"); // RULE2

	property p_viol_sticky;
		@(posedge clock_in) disable iff (srst_in)
		(viol_flag_out && !viol_clr_in) |=> viol_flag_out;
	endproperty
	a_viol_sticky: assert property (p_viol_sticky) else $error("Violation flag lost"); // RULE9

	property p_dbg_deny;
		@(posedge clock_in) disable iff (srst_in)
		(data_req_in && data_dbg_in && !data_we_in && xo_mask_in[data_addr_in[FBP_ADDR_W-1:FBP_UNIT_LSB]])
			|=> (data_valid_out && data_denied_out && data_rdata_out == FBP_DENIED_WORD);
	endproperty
	a_dbg_deny: assert property (p_dbg_deny) else $error("Debugger read of execute-only unit leaked"); // RULE7
endmodule : fbp_flash_guard
`default_nettype wire

// File: bench/fbp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_host_model
	import fbp_pkg::*;
(
	input  wire logic                     clock_in,
	input  wire logic                     fetch_valid_in,
	input  wire logic [FBP_WORD_W-1:0]    fetch_rdata_in,
	input  wire logic                     data_valid_in,
	input  wire logic [FBP_WORD_W-1:0]    data_rdata_in,
	input  wire logic                     data_denied_in,
	input  wire logic                     erase_busy_in,
	input  wire logic                     erase_done_in,
	output logic                          fetch_req_out,
	output logic [FBP_ADDR_W-1:0]         fetch_addr_out,
	output logic                          data_req_out,
	output logic                          data_dbg_out,
	output logic                          data_we_out,
	output logic [FBP_ADDR_W-1:0]         data_addr_out,
	output logic [FBP_WORD_W-1:0]         data_wdata_out,
	output logic                          erase_req_out,
	output logic [FBP_BLK_IDX_W-1:0]      erase_blk_out
);
	initial begin
		fetch_req_out = 1'b0;
		fetch_addr_out = '0;
		data_req_out = 1'b0;
		data_dbg_out = 1'b0;
		data_we_out = 1'b0;
		data_addr_out = '0;
		data_wdata_out = '0;
		erase_req_out = 1'b0;
		erase_blk_out = '0;
	end
	// Kind 0 fetch, 1 data read, 2 debugger read; answer sampled one cycle on
	task automatic rd(input int k, input logic [FBP_ADDR_W-1:0] a, output logic [31:0] d, output logic den,
		output logic ok);
		@(posedge clock_in);
		#1;
		fetch_req_out = (k == 0);
		fetch_addr_out = a;
		data_req_out = (k != 0);
		data_dbg_out = (k == 2);
		data_addr_out = a;
		@(posedge clock_in);
		#1;
		fetch_req_out = 1'b0;
		data_req_out = 1'b0;
		fetch_addr_out = ~a;
		data_addr_out = ~a;
		ok = (k == 0) ? fetch_valid_in : data_valid_in;
		d = (k == 0) ? fetch_rdata_in : data_rdata_in;
		den = data_denied_in;
	endtask : rd
	task automatic wr(input logic [FBP_ADDR_W-1:0] a, input logic [31:0] w);
		@(posedge clock_in);
		#1;
		data_req_out = 1'b1;
		data_we_out = 1'b1;
		data_addr_out = a;
		data_wdata_out = w;
		@(posedge clock_in);
		#1;
		data_req_out = 1'b0;
		data_we_out = 1'b0;
		data_addr_out = ~a;
		data_wdata_out = ~w;
	endtask : wr
	// Returns busy just after the taking edge, then cycles until done
	task automatic er(input logic [5:0] b, output logic bsy, output int n);
		@(posedge clock_in);
		#1;
		erase_req_out = 1'b1;
		erase_blk_out = b;
		@(posedge clock_in);
		#1;
		erase_req_out = 1'b0;
		erase_blk_out = ~b;
		bsy = erase_busy_in;
		n = 0;
		while (bsy && !erase_done_in && n < 300) begin
			@(posedge clock_in);
			#1;
			n++;
		end
	endtask : er
endmodule : fbp_host_model
`default_nettype wire

// File: bench/fbp_flash_guard_bench.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_flash_guard_bench;
	import fbp_pkg::*;
	logic clock_in, srst_in, viol_clr, f_req, f_val, d_req, d_dbg, d_we, d_val, d_den, e_req, busy, done, viol;
	logic [13:0] f_addr, d_addr, a;
	logic [31:0] f_rd, d_rd, d_wd, ro, xo, w, w0, d;
	logic [5:0]  e_blk;
	logic [15:0] st;
	logic        den, ok, bsy;
	int          err_total, cmp_count, cyc, n;
	fbp_flash_guard dut (.clock_in(clock_in), .srst_in(srst_in), .ro_mask_in(ro), .xo_mask_in(xo),
		.fetch_req_in(f_req), .fetch_addr_in(f_addr), .data_req_in(d_req), .data_dbg_in(d_dbg),
		.data_we_in(d_we), .data_addr_in(d_addr), .data_wdata_in(d_wd), .erase_req_in(e_req),
		.erase_blk_in(e_blk), .viol_clr_in(viol_clr), .fetch_valid_out(f_val), .fetch_rdata_out(f_rd),
		.data_valid_out(d_val), .data_rdata_out(d_rd), .data_denied_out(d_den), .erase_busy_out(busy),
		.erase_done_out(done), .viol_flag_out(viol));
	fbp_host_model host (.clock_in(clock_in), .fetch_valid_in(f_val), .fetch_rdata_in(f_rd),
		.data_valid_in(d_val), .data_rdata_in(d_rd), .data_denied_in(d_den), .erase_busy_in(busy),
		.erase_done_in(done), .fetch_req_out(f_req), .fetch_addr_out(f_addr), .data_req_out(d_req),
		.data_dbg_out(d_dbg), .data_we_out(d_we), .data_addr_out(d_addr), .data_wdata_out(d_wd),
		.erase_req_out(e_req), .erase_blk_out(e_blk));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk
	task automatic final_report();
		$display("compares=%0d mismatches=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	task automatic clr();
		@(posedge clock_in);
		#1;
		viol_clr = 1'b1;
		@(posedge clock_in);
		#1;
		viol_clr = 1'b0;
		chk(viol, 1'b0);
	endtask : clr
	task automatic rd3(input logic [13:0] ad, input logic [31:0] exp);
		host.rd(0, ad, d, den, ok);
		chk({ok, d}, {1'b1, exp});
		host.rd(1, ad, d, den, ok);
		chk({ok, den, d}, {2'b10, exp});
	endtask : rd3
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 8000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		{srst_in, viol_clr, ro, xo, st} = {2'b10, 64'h0, 16'h004A};
		repeat (8) @(posedge clock_in);
		#1;
		srst_in = 1'b0;
		chk({viol, busy, done}, 3'b000);
		for (int i = 0; i < 10; i++) begin
			st = lfsr(st);
			a = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : st[13:0];
			st = lfsr(st);
			w = {st, ~st};
			host.wr(a, w);
			rd3(a, w);
		end
		a = 14'h06AA;
		w0 = 32'hA5C3_1E0F;
		host.wr(a, w0);
		host.wr(14'h07AA, 32'h1234_5678);
		ro[3] = 1'b1;
		host.wr(a, 32'h0);
		@(posedge clock_in);
		#1;
		chk(viol, 1'b1);
		rd3(a, w0);
		clr();
		host.wr(14'h08AA, 32'h0BAD_F00D);
		rd3(14'h08AA, 32'h0BAD_F00D);
		chk(viol, 1'b0);
		host.er(6'd7, bsy, n);
		chk({bsy, viol}, 2'b01);
		clr();
		{ro[3], xo[3]} = 2'b01;
		host.wr(a, 32'h0);
		chk(viol, 1'b1);
		clr();
		host.er(6'd6, bsy, n);
		chk({bsy, viol}, 2'b01);
		clr();
		host.rd(0, a, d, den, ok);
		chk({ok, den, d}, {2'b10, w0});
		for (int k = 1; k < 3; k++) begin
			host.rd(k, a, d, den, ok);
			chk({ok, den, d}, {2'b11, FBP_DENIED_WORD});
		end
		@(posedge clock_in);
		#1;
		chk(viol, 1'b1);
		clr();
		xo[3] = 1'b0;
		host.er(6'd6, bsy, n);
		chk(n, 256);
		chk(done, 1'b1);
		@(posedge clock_in);
		#1;
		chk(busy, 1'b0);
		rd3(a, FBP_ERASED_WORD);
		rd3(14'h0600, FBP_ERASED_WORD);
		rd3(14'h06FF, FBP_ERASED_WORD);
		rd3(14'h07AA, 32'h1234_5678);
		// Reset in mid-run must drop the sticky flag and leave unlocked unit 5 (block 10) writable
		ro[0] = 1'b1;
		host.wr(14'h0000, 32'h0);
		chk(viol, 1'b1);
		srst_in = 1'b1;
		repeat (2) @(posedge clock_in);
		#1;
		srst_in = 1'b0;
		chk({viol, busy, done}, 3'b000);
		host.wr(14'h0A00, 32'h5A5A_0F0F);
		rd3(14'h0A00, 32'h5A5A_0F0F);
		final_report();
	end
endmodule : fbp_flash_guard_bench
`default_nettype wire
